// ===== common/xio_pkg.sv
package xio_pkg;

  // register byte offsets on the avalon slave
  localparam logic [5:0] OFS_DIR     = 6'h00;
  localparam logic [5:0] OFS_MAIN    = 6'h04;
  localparam logic [5:0] OFS_EXT_LO  = 6'h08;
  localparam logic [5:0] OFS_EXT_HI  = 6'h0C;
  localparam logic [5:0] OFS_POINT   = 6'h10;
  localparam logic [5:0] OFS_OPERAND = 6'h14;
  localparam logic [5:0] OFS_PSEL    = 6'h18;
  localparam logic [5:0] OFS_GSEL    = 6'h1C;
  localparam logic [5:0] OFS_SAVE    = 6'h20;
  localparam logic [5:0] OFS_STATUS  = 6'h24;

  // values after reset
  localparam logic [3:0]  DIR_RST     = 4'h0;
  localparam logic [15:0] MAIN_RST    = 16'h0000;
  localparam logic [31:0] EXT_RST     = 32'h0000_0000;
  localparam logic [31:0] OPERAND_RST = 32'h0000_0000;
  localparam logic [5:0]  PSEL_RST    = 6'h01;
  localparam logic [2:0]  GSEL_RST    = 3'h0;

  // point numbering
  localparam logic [5:0] PT_MAIN_FIRST = 6'h01;
  localparam logic [5:0] PT_MAIN_SMALL = 6'h08;
  localparam logic [5:0] PT_MAIN_LARGE = 6'h10;
  localparam logic [5:0] PT_EXT_FIRST  = 6'h11;
  localparam logic [5:0] PT_EXT_LAST   = 6'h30;

  // group input read selectors
  localparam logic [2:0] GSEL_MAIN = 3'h0;
  localparam logic [2:0] GSEL_G2   = 3'h2;
  localparam logic [2:0] GSEL_G3   = 3'h3;
  localparam logic [2:0] GSEL_G4   = 3'h4;

  // non-volatile store layout
  localparam int unsigned NV_DEPTH       = 8;
  localparam logic [15:0] NV_MARK        = 16'hA5C3;
  localparam logic [2:0]  NV_A_MARK      = 3'h0;
  localparam logic [2:0]  NV_A_DIR       = 3'h1;
  localparam logic [2:0]  NV_A_MAIN      = 3'h2;
  localparam logic [2:0]  NV_A_EXT_LO    = 3'h3;
  localparam logic [2:0]  NV_A_EXT_HI    = 3'h4;
  localparam logic [2:0]  NV_RESTORE_END = 3'h5;

  typedef enum logic [1:0] {PT_NOP, PT_SET, PT_CLEAR, PT_COND} point_op_t;

  typedef struct packed {
    point_op_t  op;
    logic [5:0] point;
  } point_cmd_t;

endpackage

// ===== rtl/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // pins in, synchronised levels out
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] d_out
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= d_in[i];
        s2_q[i] <= s1_q[i];
      end
    end
  end

  assign d_out = s2_q;

endmodule // pin_sync

// ===== rtl/nv_store.sv
`timescale 1ns/10ps
module nv_store (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // write port
  input  wire logic        we,
  input  wire logic [2:0]  waddr,
  input  wire logic [15:0] wdata,
  // read port, data one cycle after address
  input  wire logic [2:0]  raddr,
  output logic      [15:0] rdata
);

  // the array has no reset so its contents outlive nrst, standing in for flash
  logic [15:0] mem [xio_pkg::NV_DEPTH];
  logic [15:0] rdata_q;

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= mem[raddr];
    end
  end

  assign rdata = rdata_q;

endmodule // nv_store

// ===== rtl/ext_io_port.sv
// Notes on behaviour
// - There are 32 extended points, numbered 17 to 48, in four groups of eight (2 to 5).
// - A direction bit of one makes its whole group outputs and zero makes it inputs.
// - Direction weights 1, 2, 4 and 8 select groups 2, 3, 4 and 5 respectively.
// - With nothing saved the block starts with direction zero, so all groups are inputs.
// - A save stores direction and output states in non-volatile memory, restored at start.
// - Any single output point can be set or cleared; 1-8 and 17-48, or 1-48 if large.
// - A conditional single-point write drives the addressed output from an operand.
// - The conditional write sets the output for a nonzero operand and clears it for zero.
// - Group writes take an 8-bit main value and two 16-bit extended values (17-32, 33-48).
// - Group write bits that fall on points configured as inputs are ignored.
// - A supplied group value replaces all its bits; omitted values leave outputs alone.
// - A group input read returns the eight levels of group 0, 2, 3 or 4 as one value.
// - A single-point read returns that point's level; point 17 is bit 0 of group 2.
// - In the main output value bit 0 drives output 1, bit 1 output 2, one meaning on.
`timescale 1ns/10ps
module ext_io_port #(
  parameter bit LARGE_VARIANT = 1'b0
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // avalon-mm slave
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // main i/o points 1-16
  output logic      [15:0] main_out,
  input  wire logic [15:0] main_in,
  // extended i/o points 17-48
  input  wire logic [31:0] ext_i,
  output logic      [31:0] ext_o,
  output logic      [31:0] ext_oe
);

  typedef enum logic [1:0] {NV_IDLE, NV_RESTORE, NV_SAVE} nv_state_t;

  logic [3:0]  dir_q;
  logic [15:0] main_out_q;
  logic [31:0] ext_out_q;
  logic [31:0] operand_q;
  logic [5:0]  psel_q;
  logic [2:0]  gsel_q;
  logic        ack_q;
  logic [31:0] readdata_q;
  nv_state_t   st_q;
  logic [2:0]  idx_q;
  logic        ok_q;

  logic [47:0] in_s;
  logic [15:0] main_in_s;
  logic [31:0] ext_in_s;
  logic        wr_fire;
  logic        rd_load;
  logic        nv_idle;
  logic        save_fire;
  logic        pt_fire;
  logic        pt_val;
  logic        main_hit;
  logic        ext_hit;
  logic [3:0]  main_idx;
  logic [4:0]  ext_idx;
  logic [5:0]  main_last;
  logic [2:0]  rd_word;
  logic        ld;
  logic        nv_we;
  logic [15:0] nv_wdata;
  logic [15:0] nv_rdata;
  logic        pt_level;
  logic [7:0]  grp_level;
  logic [31:0] rd_val;
  xio_pkg::point_cmd_t pc;

  // ---------------- pins ----------------
  pin_sync #(.W(48)) u_sync (
    .clk   (clk),
    .nrst  (nrst),
    .d_in  ({ext_i, main_in}),
    .d_out (in_s)
  );
  assign main_in_s = in_s[15:0];
  assign ext_in_s  = in_s[47:16];

  assign main_out = main_out_q;
  assign ext_o    = ext_out_q;
  for (genvar g = 0; g < 4; g++) begin : g_grp
    assign ext_oe[8*g +: 8] = {8{dir_q[g]}};
  end

  // ---------------- bus handshake ----------------
  // one wait cycle per access; all accesses stall while the store is busy
  assign nv_idle     = (st_q == NV_IDLE);
  assign waitrequest = (read | write) & ~ack_q;
  assign wr_fire     = write & ack_q;
  assign rd_load     = read & ~ack_q & nv_idle;
  assign readdata    = readdata_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read | write) & ~ack_q & nv_idle;
    end
  end

  // ---------------- single point decode ----------------
  assign pc        = xio_pkg::point_cmd_t'(writedata[7:0]);
  assign pt_fire   = wr_fire & (address == xio_pkg::OFS_POINT) & byteenable[0];
  assign main_last = LARGE_VARIANT ? xio_pkg::PT_MAIN_LARGE : xio_pkg::PT_MAIN_SMALL;
  assign main_idx  = 4'(pc.point - xio_pkg::PT_MAIN_FIRST);
  assign ext_idx   = 5'(pc.point - xio_pkg::PT_EXT_FIRST);
  assign main_hit  = (pc.point >= xio_pkg::PT_MAIN_FIRST) && (pc.point <= main_last);
  assign ext_hit   = (pc.point >= xio_pkg::PT_EXT_FIRST) && (pc.point <= xio_pkg::PT_EXT_LAST)
                     && dir_q[ext_idx[4:3]];

  always_comb begin
    case (pc.op)
      xio_pkg::PT_SET:   pt_val = 1'b1;
      xio_pkg::PT_CLEAR: pt_val = 1'b0;
      xio_pkg::PT_COND:  pt_val = (operand_q != 32'h0000_0000);
      default:           pt_val = 1'b0;
    endcase
  end

  // byte lanes of a 16-bit group value map one to one on 8-point groups
  function automatic logic [15:0] grp_write(input logic [15:0] old, input logic [15:0] wd,
                                            input logic [1:0] be, input logic [1:0] dir);
    logic [15:0] m;
    m = {{8{be[1] & dir[1]}}, {8{be[0] & dir[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  // ---------------- non-volatile restore strobes ----------------
  assign rd_word = idx_q - 3'h1;
  assign ld      = (st_q == NV_RESTORE) && ok_q && (idx_q != 3'h0);

  // ---------------- direction ----------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dir_q <= xio_pkg::DIR_RST;
    end else if (ld && rd_word == xio_pkg::NV_A_DIR) begin
      dir_q <= nv_rdata[3:0];
    end else if (wr_fire && address == xio_pkg::OFS_DIR && byteenable[0]) begin
      dir_q <= writedata[3:0];
    end
  end

  // ---------------- main outputs ----------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      main_out_q <= xio_pkg::MAIN_RST;
    end else if (ld && rd_word == xio_pkg::NV_A_MAIN) begin
      main_out_q <= nv_rdata;
    end else if (wr_fire && address == xio_pkg::OFS_MAIN && byteenable[0]) begin
      main_out_q[7:0] <= writedata[7:0];
    end else if (pt_fire && main_hit && pc.op != xio_pkg::PT_NOP) begin
      main_out_q[main_idx] <= pt_val;
    end
  end

  // ---------------- extended outputs ----------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ext_out_q <= xio_pkg::EXT_RST;
    end else if (ld && rd_word == xio_pkg::NV_A_EXT_LO) begin
      ext_out_q[15:0] <= nv_rdata;
    end else if (ld && rd_word == xio_pkg::NV_A_EXT_HI) begin
      ext_out_q[31:16] <= nv_rdata;
    end else if (wr_fire && address == xio_pkg::OFS_EXT_LO) begin
      ext_out_q[15:0] <= grp_write(ext_out_q[15:0], writedata[15:0],
                                   byteenable[1:0], dir_q[1:0]);
    end else if (wr_fire && address == xio_pkg::OFS_EXT_HI) begin
      ext_out_q[31:16] <= grp_write(ext_out_q[31:16], writedata[15:0],
                                    byteenable[1:0], dir_q[3:2]);
    end else if (pt_fire && ext_hit && pc.op != xio_pkg::PT_NOP) begin
      ext_out_q[ext_idx] <= pt_val;
    end
  end

  // ---------------- operand and read selectors ----------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      operand_q <= xio_pkg::OPERAND_RST;
    end else if (wr_fire && address == xio_pkg::OFS_OPERAND) begin
      for (int b = 0; b < 4; b++) begin
        if (byteenable[b]) begin
          operand_q[8*b +: 8] <= writedata[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      psel_q <= xio_pkg::PSEL_RST;
      gsel_q <= xio_pkg::GSEL_RST;
    end else if (wr_fire && byteenable[0]) begin
      if (address == xio_pkg::OFS_PSEL) begin
        psel_q <= writedata[5:0];
      end
      if (address == xio_pkg::OFS_GSEL) begin
        gsel_q <= writedata[2:0];
      end
    end
  end

  // ---------------- input levels ----------------
  always_comb begin
    pt_level = 1'b0;
    if (psel_q >= xio_pkg::PT_MAIN_FIRST && psel_q <= main_last) begin
      pt_level = main_in_s[4'(psel_q - xio_pkg::PT_MAIN_FIRST)];
    end else if (psel_q >= xio_pkg::PT_EXT_FIRST && psel_q <= xio_pkg::PT_EXT_LAST) begin
      pt_level = ext_in_s[5'(psel_q - xio_pkg::PT_EXT_FIRST)];
    end
  end

  always_comb begin
    case (gsel_q)
      xio_pkg::GSEL_MAIN: grp_level = main_in_s[7:0];
      xio_pkg::GSEL_G2:   grp_level = ext_in_s[7:0];
      xio_pkg::GSEL_G3:   grp_level = ext_in_s[15:8];
      xio_pkg::GSEL_G4:   grp_level = ext_in_s[23:16];
      default:            grp_level = 8'h00;
    endcase
  end

  // ---------------- read data ----------------
  always_comb begin
    case (address)
      xio_pkg::OFS_DIR:     rd_val = {28'h0000000, dir_q};
      xio_pkg::OFS_MAIN:    rd_val = {16'h0000, main_out_q};
      xio_pkg::OFS_EXT_LO:  rd_val = {16'h0000, ext_out_q[15:0]};
      xio_pkg::OFS_EXT_HI:  rd_val = {16'h0000, ext_out_q[31:16]};
      xio_pkg::OFS_OPERAND: rd_val = operand_q;
      xio_pkg::OFS_PSEL:    rd_val = {18'h00000, psel_q, 7'h00, pt_level};
      xio_pkg::OFS_GSEL:    rd_val = {21'h000000, gsel_q, grp_level};
      xio_pkg::OFS_STATUS:  rd_val = {30'h00000000, ok_q, ~nv_idle};
      default:              rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readdata_q <= 32'h0000_0000;
    end else if (rd_load) begin
      readdata_q <= rd_val;
    end
  end

  // ---------------- save and restore sequencer ----------------
  // restore runs after every reset; a save snapshots while the bus is stalled
  assign save_fire = wr_fire && address == xio_pkg::OFS_SAVE && byteenable[0] && writedata[0];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q  <= NV_RESTORE;
      idx_q <= 3'h0;
      ok_q  <= 1'b0;
    end else begin
      case (st_q)
        NV_RESTORE: begin
          if (idx_q == 3'h1) begin
            // an unwritten store fails the mark check and keeps the reset values
            if (nv_rdata == xio_pkg::NV_MARK) begin
              ok_q <= 1'b1;
            end else begin
              ok_q <= 1'b0;
            end
          end
          if (idx_q == xio_pkg::NV_RESTORE_END) begin
            st_q  <= NV_IDLE;
            idx_q <= 3'h0;
          end else begin
            idx_q <= idx_q + 3'h1;
          end
        end
        NV_IDLE: begin
          if (save_fire) begin
            st_q  <= NV_SAVE;
            idx_q <= 3'h0;
          end
        end
        NV_SAVE: begin
          if (idx_q == xio_pkg::NV_A_EXT_HI) begin
            st_q  <= NV_IDLE;
            idx_q <= 3'h0;
            ok_q  <= 1'b1;
          end else begin
            idx_q <= idx_q + 3'h1;
          end
        end
        default: begin
          st_q  <= NV_IDLE;
          idx_q <= 3'h0;
        end
      endcase
    end
  end

  assign nv_we = (st_q == NV_SAVE);

  always_comb begin
    case (idx_q)
      xio_pkg::NV_A_MARK:   nv_wdata = xio_pkg::NV_MARK;
      xio_pkg::NV_A_DIR:    nv_wdata = {12'h000, dir_q};
      xio_pkg::NV_A_MAIN:   nv_wdata = main_out_q;
      xio_pkg::NV_A_EXT_LO: nv_wdata = ext_out_q[15:0];
      xio_pkg::NV_A_EXT_HI: nv_wdata = ext_out_q[31:16];
      default:              nv_wdata = 16'h0000;
    endcase
  end

  nv_store u_nv (
    .clk   (clk),
    .nrst  (nrst),
    .we    (nv_we),
    .waddr (idx_q),
    .wdata (nv_wdata),
    .raddr (idx_q),
    .rdata (nv_rdata)
  );

  // ---------------- assertions ----------------
  AST_DIR_MAP: assert property (@(posedge clk) disable iff (!nrst)
    wr_fire && address == xio_pkg::OFS_DIR && byteenable[0] && writedata[3:0] == 4'h4
    |=> ext_oe == 32'h00FF_0000)
    else $error("direction weight 4 did not enable group 4 only");

  AST_INPUT_RELEASED: assert property (@(posedge clk) disable iff (!nrst)
    dir_q == 4'h0 |-> ext_oe == 32'h0000_0000)
    else $error("pin driven while all groups are inputs");

  AST_BLANK_START: assert property (@(posedge clk) disable iff (!nrst)
    st_q == NV_RESTORE && idx_q == 3'h2 && !ok_q |-> dir_q == 4'h0 ##1 dir_q == 4'h0)
    else $error("direction not zero after restore without saved data");

  AST_SAVE_DIR: assert property (@(posedge clk) disable iff (!nrst)
    save_fire |=> ##1 nv_we && nv_wdata == {12'h000, $past(dir_q, 2)})
    else $error("saved direction word differs from direction");

  AST_RESTORE_DIR: assert property (@(posedge clk) disable iff (!nrst)
    ld && rd_word == xio_pkg::NV_A_DIR |=> dir_q == $past(nv_rdata[3:0]))
    else $error("direction not restored from store");

  AST_SET_EXT: assert property (@(posedge clk) disable iff (!nrst)
    pt_fire && ext_hit && pc.op == xio_pkg::PT_SET
    |=> ext_out_q[$past(ext_idx)] && ext_o == ext_out_q)
    else $error("single point set did not drive the point high");

  AST_COND_WRITE: assert property (@(posedge clk) disable iff (!nrst)
    pt_fire && main_hit && pc.op == xio_pkg::PT_COND
    |=> main_out_q[$past(main_idx)] == ($past(operand_q) != 32'h0000_0000))
    else $error("conditional write result does not follow operand");

  AST_MAIN_GROUP: assert property (@(posedge clk) disable iff (!nrst)
    wr_fire && address == xio_pkg::OFS_MAIN && byteenable[0] && !ld
    |=> main_out[7:0] == $past(writedata[7:0]) && $stable(main_out[15:8]))
    else $error("main group write wrong");

  AST_INPUT_IGNORED: assert property (@(posedge clk) disable iff (!nrst)
    wr_fire && address == xio_pkg::OFS_EXT_LO && dir_q[1:0] == 2'b00 && !ld
    |=> $stable(ext_out_q))
    else $error("group write changed points configured as inputs");

  AST_OMITTED_KEPT: assert property (@(posedge clk) disable iff (!nrst)
    wr_fire && address == xio_pkg::OFS_EXT_HI && byteenable[1:0] == 2'b11 && dir_q[3:2] == 2'b11
    |=> ext_out_q[31:16] == $past(writedata[15:0]) && $stable(ext_out_q[15:0]))
    else $error("group write did not replace its value or touched another");

  AST_GROUP_READ: assert property (@(posedge clk) disable iff (!nrst)
    rd_load && address == xio_pkg::OFS_GSEL && gsel_q == xio_pkg::GSEL_G3
    |=> readdata[7:0] == $past(ext_in_s[15:8]) && !waitrequest)
    else $error("group 3 read returned wrong levels");

  AST_POINT_READ: assert property (@(posedge clk) disable iff (!nrst)
    rd_load && address == xio_pkg::OFS_PSEL && psel_q == xio_pkg::PT_EXT_FIRST
    |=> readdata[0] == $past(ext_in_s[0]))
    else $error("point 17 read is not bit 0 of group 2");

endmodule // ext_io_port

// ===== bench/pin_model.sv
`timescale 1ns/10ps
// switches and relays on the connector; a pin whose group drives reads back the latch
module pin_model (
  // from the port
  input  wire logic [31:0] ext_o,
  input  wire logic [31:0] ext_oe,
  // switch levels set by the bench
  input  wire logic [31:0] sw_ext,
  input  wire logic [15:0] sw_main,
  // to the port
  output logic      [31:0] ext_i,
  output logic      [15:0] main_in
);
  // a released pin shows the switch, so a stale latch value cannot leak into reads
  assign ext_i   = (ext_oe & ext_o) | (~ext_oe & sw_ext);
  assign main_in = sw_main;
endmodule // pin_model

// ===== bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic        clk;
  logic        nrst;
  logic [5:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [15:0] main_out;
  logic [15:0] main_in;
  logic [31:0] ext_i;
  logic [31:0] ext_o;
  logic [31:0] ext_oe;
  logic [31:0] sw_ext;
  logic [15:0] sw_main;
  logic [31:0] rd_data;
  int          error_cnt;
  int          n_compared;

  ext_io_port #(.LARGE_VARIANT(1'b0)) u_dut (
    .clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .main_out(main_out), .main_in(main_in),
    .ext_i(ext_i), .ext_o(ext_o), .ext_oe(ext_oe)
  );

  pin_model u_pins (
    .ext_o(ext_o), .ext_oe(ext_oe), .sw_ext(sw_ext), .sw_main(sw_main),
    .ext_i(ext_i), .main_in(main_in)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic end_of_test();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // one avalon transfer; an edge always passes first so strobes never toggle twice at once
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    @(posedge clk);
    address    <= a;
    writedata  <= d;
    byteenable <= be;
    write      <= wr;
    read       <= ~wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 200);
    if (n >= 200) begin
      error_cnt++;
      end_of_test();
    end
    rd_data = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rd(input logic [5:0] a);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
  endtask

  // outputs land one cycle after the write edge; two edges leave margin
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  function automatic logic [31:0] dmask(input logic [3:0] w);
    return {{8{w[3]}}, {8{w[2]}}, {8{w[1]}}, {8{w[0]}}};
  endfunction

  task automatic t_reset();
    rd(xio_pkg::OFS_DIR);
    check("dir", rd_data, 32'h0000_0000);
    check("ext_oe", ext_oe, 32'h0000_0000);
    check("ext_o", ext_o, 32'h0000_0000);
    check("main_out", {16'h0000, main_out}, 32'h0000_0000);
    wr(6'h28, 32'hFFFF_FFFF);
    rd(6'h28);
    check("unmapped", rd_data, 32'h0000_0000);
  endtask

  task automatic t_direction();
    logic [3:0] w;
    for (int i = 0; i < 4; i++) begin
      w = 4'(4'h1 << i);
      wr(xio_pkg::OFS_DIR, {28'h0, w});
      settle();
      check("ext_oe", ext_oe, dmask(w));
    end
    wr(xio_pkg::OFS_DIR, 32'h0000_000F);
    settle();
    check("ext_oe", ext_oe, 32'hFFFF_FFFF);
    rd(xio_pkg::OFS_DIR);
    check("dir", rd_data, 32'h0000_000F);
    // all groups out: a full upper value replaces both bytes, lower half untouched
    wr(xio_pkg::OFS_EXT_HI, 32'h0000_3C5A);
    settle();
    check("ext_o", ext_o, 32'h3C5A_0000);
    wr(xio_pkg::OFS_EXT_HI, 32'h0000_0000);
    settle();
    check("ext_o", ext_o, 32'h0000_0000);
  endtask

  task automatic t_group_write();
    wr(xio_pkg::OFS_DIR, 32'h0000_0005);
    wr(xio_pkg::OFS_EXT_LO, 32'h0000_FFFF);
    settle();
    check("ext_o", ext_o, 32'h0000_00FF);
    wr(xio_pkg::OFS_EXT_HI, 32'h0000_FFFF);
    wr(xio_pkg::OFS_EXT_HI, 32'h0000_0007);
    settle();
    check("ext_o", ext_o, 32'h0007_00FF);
    wr(xio_pkg::OFS_MAIN, 32'h0000_FF06);
    settle();
    check("main_out", {16'h0000, main_out}, 32'h0000_0006);
    rd(xio_pkg::OFS_MAIN);
    check("main", rd_data, 32'h0000_0006);
  endtask

  task automatic point_step(input xio_pkg::point_op_t op, input logic [5:0] pt,
                            input logic [31:0] e_ext, input logic [15:0] e_main);
    wr(xio_pkg::OFS_POINT, {24'h0, op, pt});
    settle();
    check("ext_o", ext_o, e_ext);
    check("main_out", {16'h0000, main_out}, {16'h0000, e_main});
  endtask

  task automatic t_point();
    wr(xio_pkg::OFS_DIR, 32'h0000_000F);
    point_step(xio_pkg::PT_CLEAR, 6'h11, 32'h0007_00FE, 16'h0006);
    point_step(xio_pkg::PT_SET, 6'h30, 32'h8007_00FE, 16'h0006);
    point_step(xio_pkg::PT_SET, 6'h01, 32'h8007_00FE, 16'h0007);
    point_step(xio_pkg::PT_SET, 6'h09, 32'h8007_00FE, 16'h0007);
    point_step(xio_pkg::PT_SET, 6'h31, 32'h8007_00FE, 16'h0007);
    wr(xio_pkg::OFS_OPERAND, 32'h0000_0000);
    point_step(xio_pkg::PT_COND, 6'h21, 32'h8006_00FE, 16'h0007);
    point_step(xio_pkg::PT_COND, 6'h03, 32'h8006_00FE, 16'h0003);
    wr(xio_pkg::OFS_OPERAND, 32'h0001_0000);
    point_step(xio_pkg::PT_COND, 6'h28, 32'h8086_00FE, 16'h0003);
    point_step(xio_pkg::PT_COND, 6'h03, 32'h8086_00FE, 16'h0007);
    wr(xio_pkg::OFS_DIR, 32'h0000_000E);
    point_step(xio_pkg::PT_SET, 6'h14, 32'h8086_00FE, 16'h0007);
    // a no-op on a point that is on must leave it on
    point_step(xio_pkg::PT_NOP, 6'h01, 32'h8086_00FE, 16'h0007);
  endtask

  task automatic t_inputs();
    logic [2:0] sel [4];
    logic [7:0] lvl [4];
    sel = '{xio_pkg::GSEL_MAIN, xio_pkg::GSEL_G2, xio_pkg::GSEL_G3, xio_pkg::GSEL_G4};
    wr(xio_pkg::OFS_DIR, 32'h0000_0000);
    sw_ext  <= 32'hC3A5_5A81;
    sw_main <= 16'h00E7;
    repeat (4) @(posedge clk);
    wr(xio_pkg::OFS_EXT_LO, 32'h0000_FFFF);
    settle();
    check("ext_o", ext_o, 32'h8086_00FE);
    rd(xio_pkg::OFS_EXT_LO);
    check("ext_lo", rd_data, 32'h0000_00FE);
    lvl = '{8'hE7, 8'h81, 8'h5A, 8'hA5};
    for (int i = 0; i < 4; i++) begin
      wr(xio_pkg::OFS_GSEL, {29'h0, sel[i]});
      rd(xio_pkg::OFS_GSEL);
      check("group_in", rd_data, {21'h0, sel[i], lvl[i]});
    end
    wr(xio_pkg::OFS_GSEL, 32'h0000_0005);
    rd(xio_pkg::OFS_GSEL);
    check("group_in", rd_data, 32'h0000_0500);
    wr(xio_pkg::OFS_PSEL, 32'h0000_0011);
    rd(xio_pkg::OFS_PSEL);
    check("point_in", rd_data, 32'h0000_1101);
    wr(xio_pkg::OFS_PSEL, 32'h0000_0012);
    rd(xio_pkg::OFS_PSEL);
    check("point_in", rd_data, 32'h0000_1200);
    wr(xio_pkg::OFS_PSEL, 32'h0000_0018);
    rd(xio_pkg::OFS_PSEL);
    check("point_in", rd_data, 32'h0000_1801);
  endtask

  task automatic t_save();
    wr(xio_pkg::OFS_DIR, 32'h0000_0003);
    wr(xio_pkg::OFS_EXT_LO, 32'h0000_1234);
    wr(xio_pkg::OFS_SAVE, 32'h0000_0001);
    rd(xio_pkg::OFS_STATUS);
    check("status", rd_data, 32'h0000_0002);
    wr(xio_pkg::OFS_DIR, 32'h0000_0000);
    // the store keeps its words across reset, the latches do not
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd(xio_pkg::OFS_DIR);
    check("dir", rd_data, 32'h0000_0003);
    settle();
    check("ext_oe", ext_oe, 32'h0000_FFFF);
    check("ext_o", ext_o, 32'h8086_1234);
    check("main_out", {16'h0000, main_out}, 32'h0000_0007);
  endtask

  initial begin
    error_cnt  = 0;
    n_compared = 0;
    nrst       = 1'b0;
    address    = 6'h00;
    read       = 1'b0;
    write      = 1'b0;
    writedata  = 32'h0000_0000;
    byteenable = 4'h0;
    sw_ext     = 32'h0000_0000;
    sw_main    = 16'h0000;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_direction();
    t_group_write();
    t_point();
    t_inputs();
    t_save();
    end_of_test();
  end
endmodule // tb_top
